// ===== logic/rhs_pkg.sv
// Constants and types shared by the root hub status register logic.
// What this block does
// - Three removability bits, bit 0 reserved.
// - Low word status, high word change flags.
// - Read 14h, write 94h, reset zero.
// - Bit 31 one clears wake enable.
// - Bit 15 one sets wake enable; readable.
// - Wake enable makes attach change resume while the bus is suspended.
// - Overcurrent indicator change sets bit 17.
// - Writing one clears bit 17; zero ignored.
// - Bits 16 and 0 always read zero.
// - Global mode: bit 16 powers all valid ports.
// - Per-port mode: bit 16 powers unmasked ports.
// - Global mode: bit 0 unpowers all valid ports.
// - Per-port mode: bit 0 unpowers unmasked ports.
// - Bit 1 shows global overcurrent condition.
// - Per-port overcurrent reporting forces bit 1 zero.
// - Per-port mode: masked ports follow only per-port power commands.
package rhs_pkg;
	localparam logic [7:0]  RHS_CODE_DESC_B_RD = 8'h13;
	localparam logic [7:0]  RHS_CODE_DESC_B_WR = 8'h93;
	localparam logic [7:0]  RHS_CODE_STATUS_RD = 8'h14;
	localparam logic [7:0]  RHS_CODE_STATUS_WR = 8'h94;
	localparam int          RHS_BIT_CLR_WAKE   = 31;
	localparam int          RHS_BIT_OC_CHANGE  = 17;
	localparam int          RHS_BIT_SET_POWER  = 16;
	localparam int          RHS_BIT_WAKE_EN    = 15;
	localparam int          RHS_BIT_OC_FLAG    = 1;
	localparam int          RHS_BIT_CLR_POWER  = 0;
	localparam int          RHS_MASK_LSB       = 16;
	localparam int          RHS_FIXED_LSB      = 0;
	localparam int          RHS_PORTS          = 3;
	localparam logic [2:0]  RHS_PORT_VALID     = 3'h6;
	localparam logic [2:0]  RHS_MASK_RESET     = 3'h0;
	localparam logic [2:0]  RHS_FIXED_RESET    = 3'h0;
	localparam logic [31:0] RHS_STATUS_RESET   = 32'h00000000;

	typedef struct packed {
		logic        valid;
		logic [7:0]  code;
		logic [31:0] wdata;
	} rhs_cmd_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] data;
	} rhs_rsp_t;
endpackage

// ===== logic/rhs_root_hub_status.sv
// Root hub status and removability register logic.
`timescale 1ns/1ns
`default_nettype none
module rhs_root_hub_status
	import rhs_pkg::*;
(
	input  wire logic                 mclk,
	input  wire logic                 reset,
	input  wire rhs_cmd_t             cmd,
	input  wire logic                 per_port_switch_select,
	input  wire logic                 per_port_oc_select,
	input  wire logic                 overcurrent_pin,
	input  wire logic                 attach_change_flag,
	input  wire logic                 bus_suspended_state,
	input  wire logic [RHS_PORTS-1:0] port_power_set_req,
	input  wire logic [RHS_PORTS-1:0] port_power_clr_req,
	output rhs_rsp_t                  rsp,
	output logic [RHS_PORTS-1:0]      port_powered_state,
	output logic [RHS_PORTS-1:0]      port_power_mask,
	output logic [RHS_PORTS-1:0]      port_fixed_device_flags,
	output logic                      remote_wake_enable,
	output logic                      bus_resuming_state,
	output logic                      resume_seen_irq
);
	rhs_rsp_t             rsp_reg, rsp_next;
	logic [RHS_PORTS-1:0] power_reg, power_next;
	logic [RHS_PORTS-1:0] mask_reg, mask_next;
	logic [RHS_PORTS-1:0] fixed_reg, fixed_next;
	logic                 wake_reg, wake_next;
	logic                 ochg_reg, ochg_next;
	logic                 ovc_reg, ovc_next;
	logic                 oc_meta_reg, oc_sync_reg;
	logic                 attach_d_reg;
	logic                 resume_reg, resume_next;
	logic                 irq_reg, irq_next;
	logic                 wr_status, wr_desc;
	logic [RHS_PORTS-1:0] global_ports;

	function automatic logic [31:0] status_word(input logic wake, input logic ochg,
			input logic ovc);
		logic [31:0] w;
		w = RHS_STATUS_RESET;
		w[RHS_BIT_WAKE_EN]   = wake;
		w[RHS_BIT_OC_CHANGE] = ochg;
		w[RHS_BIT_OC_FLAG]   = ovc;
		return w;
	endfunction

	assign wr_status = cmd.valid && (cmd.code == RHS_CODE_STATUS_WR);
	assign wr_desc   = cmd.valid && (cmd.code == RHS_CODE_DESC_B_WR);
	// In global mode the mask is not valid, so every valid port (1 and 2) follows the global commands.
	assign global_ports = per_port_switch_select ? (~mask_reg & RHS_PORT_VALID)
		: RHS_PORT_VALID;

	always_comb begin
		rsp_next    = '0;
		power_next  = power_reg;
		mask_next   = mask_reg;
		fixed_next  = fixed_reg;
		wake_next   = wake_reg;
		ochg_next   = ochg_reg;
		ovc_next    = per_port_oc_select ? 1'b0 : oc_sync_reg;
		resume_next = 1'b0;
		irq_next    = 1'b0;
		if (cmd.valid) begin
			unique case (cmd.code)
				RHS_CODE_STATUS_RD: begin
					rsp_next.valid = 1'b1;
					rsp_next.data  = status_word(wake_reg, ochg_reg, ovc_reg);
				end
				RHS_CODE_DESC_B_RD: begin
					rsp_next.valid = 1'b1;
					rsp_next.data[RHS_MASK_LSB +: RHS_PORTS]  = mask_reg;
					rsp_next.data[RHS_FIXED_LSB +: RHS_PORTS] = fixed_reg;
				end
				default: begin
					rsp_next = '0;
				end
			endcase
		end
		if (wr_desc) begin
			mask_next  = cmd.wdata[RHS_MASK_LSB +: RHS_PORTS] & RHS_PORT_VALID;
			fixed_next = cmd.wdata[RHS_FIXED_LSB +: RHS_PORTS] & RHS_PORT_VALID;
		end
		if (wr_status) begin
			if (cmd.wdata[RHS_BIT_WAKE_EN])
				wake_next = 1'b1;
			if (cmd.wdata[RHS_BIT_CLR_WAKE])
				wake_next = 1'b0;
			if (cmd.wdata[RHS_BIT_OC_CHANGE])
				ochg_next = 1'b0;
		end
		// A change arriving with the clear still sets the flag.
		if (ovc_next != ovc_reg)
			ochg_next = 1'b1;
		for (int i = 0; i < RHS_PORTS; i++) begin
			if (RHS_PORT_VALID[i]) begin
				if (per_port_switch_select && mask_reg[i]) begin
					if (port_power_set_req[i])
						power_next[i] = 1'b1;
					if (port_power_clr_req[i])
						power_next[i] = 1'b0;
				end
				if (wr_status && global_ports[i]) begin
					if (cmd.wdata[RHS_BIT_SET_POWER])
						power_next[i] = 1'b1;
					if (cmd.wdata[RHS_BIT_CLR_POWER])
						power_next[i] = 1'b0;
				end
			end else begin
				power_next[i] = 1'b0;
			end
		end
		if (wake_reg && bus_suspended_state && attach_change_flag && !attach_d_reg) begin
			resume_next = 1'b1;
			irq_next    = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		oc_meta_reg <= overcurrent_pin;
		oc_sync_reg <= oc_meta_reg;
		if (reset) begin
			rsp_reg      <= '0;
			power_reg    <= '0;
			mask_reg     <= RHS_MASK_RESET;
			fixed_reg    <= RHS_FIXED_RESET;
			wake_reg     <= 1'b0;
			ochg_reg     <= 1'b0;
			ovc_reg      <= 1'b0;
			attach_d_reg <= 1'b0;
			resume_reg   <= 1'b0;
			irq_reg      <= 1'b0;
		end else begin
			rsp_reg      <= rsp_next;
			power_reg    <= power_next;
			mask_reg     <= mask_next;
			fixed_reg    <= fixed_next;
			wake_reg     <= wake_next;
			ochg_reg     <= ochg_next;
			ovc_reg      <= ovc_next;
			attach_d_reg <= attach_change_flag;
			resume_reg   <= resume_next;
			irq_reg      <= irq_next;
		end
	end

	assign rsp                     = rsp_reg;
	assign port_powered_state      = power_reg;
	assign port_power_mask         = mask_reg;
	assign port_fixed_device_flags = fixed_reg;
	assign remote_wake_enable      = wake_reg;
	assign bus_resuming_state      = resume_reg;
	assign resume_seen_irq         = irq_reg;
endmodule // rhs_root_hub_status
`default_nettype wire

// ===== tb/rhs_status_properties.sv
// Assertions on the ports of the root hub status register logic.
`timescale 1ns/1ns
`default_nettype none
module rhs_status_check
	import rhs_pkg::*;
(
	input wire logic                 mclk,
	input wire logic                 reset,
	input wire rhs_cmd_t             cmd,
	input wire logic                 per_port_switch_select,
	input wire logic                 attach_change_flag,
	input wire logic                 bus_suspended_state,
	input wire rhs_rsp_t             rsp,
	input wire logic [RHS_PORTS-1:0] port_powered_state,
	input wire logic                 remote_wake_enable,
	input wire logic                 resume_seen_irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	wire logic st_wr = cmd.valid && cmd.code == RHS_CODE_STATUS_WR;
	wire logic gmode = !per_port_switch_select;
	property p_rd; cmd.valid && cmd.code == RHS_CODE_STATUS_RD |=> rsp.valid; endproperty
	a_rd: assert property (p_rd) else $error("read not answered");
	property p_zero; rsp.valid |-> !rsp.data[16] && !rsp.data[0]; endproperty
	a_zero: assert property (p_zero) else $error("bit 16 or 0 read high");
	property p_set; st_wr && cmd.wdata[15] && !cmd.wdata[31] |=> remote_wake_enable; endproperty
	a_set: assert property (p_set) else $error("wake enable not set");
	property p_clr; st_wr && cmd.wdata[31] |=> !remote_wake_enable; endproperty
	a_clr: assert property (p_clr) else $error("wake enable not cleared");
	property p_hold; !st_wr |=> $stable(remote_wake_enable); endproperty
	a_hold: assert property (p_hold) else $error("wake enable moved");
	property p_gon; st_wr && gmode && cmd.wdata[16] && !cmd.wdata[0] |=> port_powered_state == 3'h6;
	endproperty
	a_gon: assert property (p_gon) else $error("global power on failed");
	property p_goff; st_wr && gmode && cmd.wdata[0] |=> port_powered_state == 3'h0; endproperty
	a_goff: assert property (p_goff) else $error("global power off failed");
	property p_res;
		remote_wake_enable && bus_suspended_state && $rose(attach_change_flag) |=> resume_seen_irq;
	endproperty
	a_res: assert property (p_res) else $error("resume not raised");
	property p_nores; !remote_wake_enable |=> !resume_seen_irq; endproperty
	a_nores: assert property (p_nores) else $error("resume raised while disabled");
endmodule // rhs_status_check
`default_nettype wire

// ===== tb/test_root_hub_status_regs.sv
// Self-checking bench for the root hub status register logic.
`timescale 1ns/1ns
`default_nettype none
module test_root_hub_status_regs;
	import rhs_pkg::*;
	logic       mclk = 0, reset = 1, pps = 0, poc = 0, ocp = 0, att = 0, susp = 0;
	logic [2:0] pset = 0, pclr = 0, pw, msk, fix;
	logic       wake, bres, irq;
	rhs_cmd_t   cmd = '0;
	rhs_rsp_t   rsp, rd;
	int         err_total = 0, cmp_count = 0, cyc = 0;
	rhs_root_hub_status uut(.mclk(mclk), .reset(reset), .cmd(cmd), .per_port_switch_select(pps),
		.per_port_oc_select(poc), .overcurrent_pin(ocp), .attach_change_flag(att),
		.bus_suspended_state(susp), .port_power_set_req(pset), .port_power_clr_req(pclr),
		.rsp(rsp), .port_powered_state(pw), .port_power_mask(msk),
		.port_fixed_device_flags(fix), .remote_wake_enable(wake), .bus_resuming_state(bres),
		.resume_seen_irq(irq));
	initial forever #50 mclk = ~mclk;
	task conclude;
		if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [32:0] s, input logic [32:0] e);
		cmp_count++;
		if (s !== e) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task acc(input logic [7:0] c, input logic [31:0] d);
		@(negedge mclk);
		cmd <= '{1'b1, c, d};
		@(posedge mclk);
		#1 rd = rsp;
		@(negedge mclk);
		cmd <= '0;
	endtask
	task rdc(input logic [31:0] e);
		acc(RHS_CODE_STATUS_RD, 32'h0);
		chk(rd, {1'b1, e});
	endtask
	always @(posedge mclk) if (++cyc == 3000) begin
		err_total++;
		conclude;
	end
	initial begin
		repeat (12) @(negedge mclk);
		reset = 0;
		rdc(32'h0);
		acc(8'h94, 32'h00000002);
		rdc(32'h0);
		acc(8'h94, 32'h00008000);
		acc(8'h94, 32'h0);
		rdc(32'h00008000);
		acc(8'h94, 32'h80000000);
		rdc(32'h0);
		acc(8'h93, 32'h00040007);
		chk(33'(fix), 33'h6);
		chk(33'(msk), 33'h4);
		acc(RHS_CODE_DESC_B_RD, 32'h0);
		chk(rd, 33'h100040006);
		acc(8'h94, 32'h00010000);
		chk(33'(pw), 33'h6);
		acc(8'h94, 32'h1);
		chk(33'(pw), 33'h0);
		pps = 1;
		acc(8'h94, 32'h00010000);
		chk(33'(pw), 33'h2);
		pset = 3'h4;
		@(negedge mclk);
		pset = 0;
		chk(33'(pw), 33'h6);
		acc(8'h94, 32'h1);
		chk(33'(pw), 33'h4);
		pclr = 3'h4;
		@(negedge mclk);
		pclr = 0;
		chk(33'(pw), 33'h0);
		ocp = 1;
		repeat (5) @(negedge mclk);
		rdc(32'h00020002);
		acc(8'h94, 32'h00020000);
		rdc(32'h2);
		poc = 1;
		acc(RHS_CODE_STATUS_RD, 32'h0);
		chk(rd & 33'h2, 33'h0);
		acc(8'h94, 32'h00008000);
		susp = 1;
		att = 1;
		@(posedge mclk);
		#1 chk(33'({bres, irq}), 33'h3);
		acc(8'h94, 32'h80000000);
		att = 0;
		@(negedge mclk);
		att = 1;
		@(posedge mclk);
		#1 chk(33'(irq), 33'h0);
		conclude;
	end
endmodule // test_root_hub_status_regs
bind rhs_root_hub_status rhs_status_check u_chk(.mclk(mclk), .reset(reset), .cmd(cmd),
	.per_port_switch_select(per_port_switch_select), .attach_change_flag(attach_change_flag),
	.bus_suspended_state(bus_suspended_state), .rsp(rsp), .port_powered_state(port_powered_state),
	.remote_wake_enable(remote_wake_enable), .resume_seen_irq(resume_seen_irq));
`default_nettype wire
